// ### design/sdsi_pkg.sv
// constants for the drop counter, drop capture and interrupt registers
// Operation
// R1 - count port-two ingress rate-limit drops
// R2 - counter read returns value, then zeroes
// R3 - counter saturates at all ones
// R4 - mask bit one blocks interrupts, resets one
// R5 - mask never affects captured pending status
// R6 - pending holds two capture slots A, B
// R7 - bit 0 marks slot A valid
// R8 - slot A port in bits 2:1
// R9 - slot A reason uses slot B encoding
// R10 - bit 7 slot B pending, reason 13:10
// R11 - slot B port in bits 9:8
// R12 - reasons 0000, 0001, 0010 defined
// R13 - reasons 0011, 0100 defined
// R14 - reasons 0101, 0110 defined
// R15 - 1001 yellow drop; others reserved, unreported
// R16 - pending read clears all fields
// R17 - fill slot A, then B, then hold
// R18 - irq while slot flagged and unmasked
package sdsi_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 32;
  // printed offsets are word indices; byte address is four times
  localparam logic [15:0] IDX_DROP_CNT  = 16'h1c18;
  localparam logic [15:0] IDX_MASK      = 16'h1c20;
  localparam logic [15:0] IDX_PENDING   = 16'h1c21;
  localparam logic [15:0] IDX_EVT_STAT  = 16'h1c22;
  localparam logic [15:0] IDX_EVT_EN    = 16'h1c23;
  localparam logic [15:0] ADR_DROP_CNT  = 16'(IDX_DROP_CNT << 2);
  localparam logic [15:0] ADR_MASK      = 16'(IDX_MASK << 2);
  localparam logic [15:0] ADR_PENDING   = 16'(IDX_PENDING << 2);
  localparam logic [15:0] ADR_EVT_STAT  = 16'(IDX_EVT_STAT << 2);
  localparam logic [15:0] ADR_EVT_EN    = 16'(IDX_EVT_EN << 2);
  localparam logic [31:0] DROP_CNT_RST  = 32'h00000000;
  localparam logic        MASK_RST      = 1'b1;
  localparam logic [2:0]  EVT_EN_RST    = 3'h0;
  // pending field positions
  localparam int          A_VALID_BIT   = 0;
  localparam int          A_PORT_LSB    = 1;
  localparam int          A_REASON_LSB  = 3;
  localparam int          B_PEND_BIT    = 7;
  localparam int          B_PORT_LSB    = 8;
  localparam int          B_REASON_LSB  = 10;
  // event status bits
  localparam int          EVT_CAPTURE   = 0;
  localparam int          EVT_SATURATE  = 1;
  localparam int          EVT_LOST      = 2;
  localparam int          EVT_N         = 3;
  localparam logic [1:0]  PORT_RSVD     = 2'h3;
  typedef enum logic [3:0] {
    RSN_BCAST_LEVEL = 4'b0000,
    RSN_RED         = 4'b0001,
    RSN_NO_BUF      = 4'b0010,
    RSN_NO_DESC     = 4'b0011,
    RSN_NO_DEST     = 4'b0100,
    RSN_RX_ERR      = 4'b0101,
    RSN_DROP_LEVEL  = 4'b0110,
    RSN_YELLOW      = 4'b1001
  } sdsi_reason_e;
endpackage : sdsi_pkg

// ### design/sdsi_cnt_if.sv
// link between the register bank and the saturating drop counter
`timescale 1ns/1ns
interface sdsi_cnt_if #(parameter int W = 32);
  logic         inc;
  logic         clr;
  logic [W-1:0] count;
  logic         at_max;
  modport bank (output inc, output clr, input count, input at_max);
  modport ctr  (input inc, input clr, output count, output at_max);
endinterface : sdsi_cnt_if

// ### design/sdsi_drop_counter.sv
// saturating clear-on-read drop counter
`timescale 1ns/1ns
module sdsi_drop_counter #(
  parameter int W = 32
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  sdsi_cnt_if.ctr    cnt
);
  logic [W-1:0] count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= W'(sdsi_pkg::DROP_CNT_RST);
    end else if (cnt.clr) begin
      // an increment in the clearing cycle is kept
      count_q <= cnt.inc ? W'(1) : '0; // R2
    end else if (cnt.inc && count_q != '1) begin // R3
      count_q <= count_q + W'(1); // R1
    end
  end

  assign cnt.count  = count_q;
  assign cnt.at_max = (count_q == '1);
endmodule : sdsi_drop_counter

// ### design/sdsi_switch_drop_status_irq.sv
// register bank: port-two drop counter, drop capture slots and interrupt
`timescale 1ns/1ns
module sdsi_switch_drop_status_irq #(
  parameter int CNT_W = 32
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        drop_valid,
  input  wire logic        drop_rate_limited,
  input  wire logic [1:0]  drop_port,
  input  wire logic [3:0]  drop_reason,
  output logic             irq
);
  sdsi_cnt_if #(.W(CNT_W)) cnt ();

  sdsi_drop_counter #(.W(CNT_W)) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .cnt     (cnt)
  );

  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        mask_q;
  logic        a_valid_q;
  logic [1:0]  a_port_q;
  logic [3:0]  a_reason_q;
  logic        b_pend_q;
  logic [1:0]  b_port_q;
  logic [3:0]  b_reason_q;
  logic [sdsi_pkg::EVT_N-1:0] evt_stat_q;
  logic [sdsi_pkg::EVT_N-1:0] evt_en_q;
  logic        sat_seen_q;

  function automatic logic reason_ok(input logic [3:0] r);
    unique case (r)
      sdsi_pkg::RSN_BCAST_LEVEL, sdsi_pkg::RSN_RED, sdsi_pkg::RSN_NO_BUF, // R12
      sdsi_pkg::RSN_NO_DESC, sdsi_pkg::RSN_NO_DEST,                      // R13
      sdsi_pkg::RSN_RX_ERR, sdsi_pkg::RSN_DROP_LEVEL,                    // R14
      sdsi_pkg::RSN_YELLOW: reason_ok = 1'b1;                            // R15
      default:              reason_ok = 1'b0;                            // R15
    endcase
  endfunction : reason_ok

  function automatic logic is_reg(input logic [15:0] a);
    is_reg = (a == sdsi_pkg::ADR_DROP_CNT) || (a == sdsi_pkg::ADR_MASK) ||
             (a == sdsi_pkg::ADR_PENDING) || (a == sdsi_pkg::ADR_EVT_STAT) ||
             (a == sdsi_pkg::ADR_EVT_EN);
  endfunction : is_reg

  // reads take effect in the setup cycle so read data and clear share one edge
  logic setup_rd;
  logic acc_wr;
  logic rd_cnt;
  logic rd_pend;
  logic drop_ok;
  logic to_a;
  logic to_b;
  logic lost;
  logic sat_rise;
  logic [31:0] pend_word;

  always_comb begin
    setup_rd = psel && !penable && !pwrite;
    acc_wr   = psel && penable && pready_q && pwrite;
    rd_cnt   = setup_rd && paddr == sdsi_pkg::ADR_DROP_CNT;
    rd_pend  = setup_rd && paddr == sdsi_pkg::ADR_PENDING;
    drop_ok  = drop_valid && reason_ok(drop_reason) && drop_port != sdsi_pkg::PORT_RSVD;
    // a cleared pair reopens slot A in the same cycle
    to_a     = drop_ok && (rd_pend || !a_valid_q); // R17
    to_b     = drop_ok && !rd_pend && a_valid_q && !b_pend_q; // R17
    lost     = drop_ok && !to_a && !to_b;
    sat_rise = cnt.at_max && !sat_seen_q;
    pend_word = '0;
    pend_word[sdsi_pkg::A_VALID_BIT] = a_valid_q; // R7
    pend_word[sdsi_pkg::A_PORT_LSB +: 2] = a_port_q; // R8
    pend_word[sdsi_pkg::A_REASON_LSB +: 4] = a_reason_q; // R9
    pend_word[sdsi_pkg::B_PEND_BIT] = b_pend_q; // R10
    pend_word[sdsi_pkg::B_PORT_LSB +: 2] = b_port_q; // R11
    pend_word[sdsi_pkg::B_REASON_LSB +: 4] = b_reason_q; // R10
  end

  assign cnt.inc = drop_valid && drop_rate_limited && drop_port == 2'h2; // R1
  assign cnt.clr = rd_cnt; // R2

  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !is_reg(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_rd) begin
      unique case (paddr)
        sdsi_pkg::ADR_DROP_CNT: prdata_q <= 32'(cnt.count); // R2
        sdsi_pkg::ADR_MASK:     prdata_q <= {31'h0, mask_q};
        sdsi_pkg::ADR_PENDING:  prdata_q <= pend_word;
        sdsi_pkg::ADR_EVT_STAT: prdata_q <= 32'(evt_stat_q);
        sdsi_pkg::ADR_EVT_EN:   prdata_q <= 32'(evt_en_q);
        default:                prdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q   <= sdsi_pkg::MASK_RST; // R4
      evt_en_q <= sdsi_pkg::EVT_EN_RST;
    end else if (acc_wr) begin
      if (paddr == sdsi_pkg::ADR_MASK) begin
        mask_q <= pwdata[0]; // R4
      end
      if (paddr == sdsi_pkg::ADR_EVT_EN) begin
        evt_en_q <= pwdata[sdsi_pkg::EVT_N-1:0];
      end
    end
  end

  // capture is independent of the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_valid_q  <= 1'b0;
      a_port_q   <= 2'h0;
      a_reason_q <= 4'h0;
    end else if (to_a) begin // R5
      a_valid_q  <= 1'b1; // R6
      a_port_q   <= drop_port; // R8
      a_reason_q <= drop_reason; // R9
    end else if (rd_pend) begin
      a_valid_q  <= 1'b0; // R16
      a_port_q   <= 2'h0;
      a_reason_q <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_pend_q   <= 1'b0;
      b_port_q   <= 2'h0;
      b_reason_q <= 4'h0;
    end else if (to_b) begin // R5
      b_pend_q   <= 1'b1; // R6
      b_port_q   <= drop_port; // R11
      b_reason_q <= drop_reason; // R10
    end else if (rd_pend) begin
      b_pend_q   <= 1'b0; // R16
      b_port_q   <= 2'h0;
      b_reason_q <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_seen_q <= 1'b0;
    end else begin
      sat_seen_q <= cnt.at_max;
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  logic [sdsi_pkg::EVT_N-1:0] evt_set;
  logic [sdsi_pkg::EVT_N-1:0] evt_clr;
  always_comb begin
    evt_set = '0;
    evt_set[sdsi_pkg::EVT_CAPTURE]  = to_a || to_b;
    evt_set[sdsi_pkg::EVT_SATURATE] = sat_rise;
    evt_set[sdsi_pkg::EVT_LOST]     = lost;
    evt_clr = (acc_wr && paddr == sdsi_pkg::ADR_EVT_STAT) ?
              pwdata[sdsi_pkg::EVT_N-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_q <= '0;
    end else begin
      evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !mask_q && (a_valid_q || b_pend_q || |(evt_stat_q & evt_en_q)); // R4 R18
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
endmodule : sdsi_switch_drop_status_irq

// ### sim/sdsi_switch_drop_status_irq_sva.sv
// assertion checker for the drop status and interrupt register bank
`timescale 1ns/1ns
module sdsi_switch_drop_status_irq_sva #(
  parameter int CNT_W = 32
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [15:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        drop_valid,
  input wire logic        drop_rate_limited,
  input wire logic [1:0]  drop_port,
  input wire logic [3:0]  drop_reason,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire rd_pnd = setup && !pwrite && paddr == sdsi_pkg::ADR_PENDING;
  wire rd_cnt = setup && !pwrite && paddr == sdsi_pkg::ADR_DROP_CNT;
  wire inc = drop_valid && drop_rate_limited && drop_port == 2'h2;
  wire legal = drop_port != 2'h3 && (drop_reason <= 4'h6 || drop_reason == 4'h9);
  wire mapped = paddr inside {sdsi_pkg::ADR_DROP_CNT, sdsi_pkg::ADR_MASK,
    sdsi_pkg::ADR_PENDING, sdsi_pkg::ADR_EVT_STAT, sdsi_pkg::ADR_EVT_EN};
  logic mask_q;
  logic pnd_clr_q;
  logic cnt_clr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_q <= 1'b1;
    else if (pready && pwrite && paddr == sdsi_pkg::ADR_MASK) mask_q <= pwdata[0];
  end
  // slots known empty: set by a read, lost on any drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pnd_clr_q <= 1'b1;
    else if (drop_valid) pnd_clr_q <= 1'b0;
    else if (rd_pnd) pnd_clr_q <= 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_clr_q <= 1'b1;
    else if (inc) cnt_clr_q <= 1'b0;
    else if (rd_cnt) cnt_clr_q <= 1'b1;
  end
  a_ready_after_setup: assert property (setup |=> pready) else $error("no ready");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(setup))
    else $error("stray ready");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("bad slverr");
  a_err_data_zero: assert property (setup && !pwrite && !mapped |=> prdata == 32'h0)
    else $error("unmapped data");
  a_pend_read_clears: assert property (rd_pnd && pnd_clr_q && !drop_valid |=> prdata == 32'h0)
    else $error("pending not cleared");
  a_cnt_read_clears: assert property (rd_cnt && cnt_clr_q && !inc |=> prdata == 32'h0)
    else $error("counter not cleared");
  a_irq_masked: assert property ($past(mask_q) |-> !irq) else $error("masked irq");
  a_irq_on_capture: assert property (drop_valid && legal ##1 !mask_q |=> irq)
    else $error("irq missing");
  a_mask_readback: assert property (setup && !pwrite && paddr == sdsi_pkg::ADR_MASK
    |=> prdata == {31'h0, mask_q}) else $error("mask read");
  a_pend_rsvd_zero: assert property (rd_pnd |=> prdata[31:14] == 18'h0)
    else $error("reserved bits");
  c_slot_b: cover property (rd_pnd ##1 prdata[7]);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule : sdsi_switch_drop_status_irq_sva
bind sdsi_switch_drop_status_irq sdsi_switch_drop_status_irq_sva #(.CNT_W(CNT_W)) sva_inst (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .drop_valid, .drop_rate_limited, .drop_port, .drop_reason, .irq);

// ### sim/tb.sv
// self-checking bench for the drop status and interrupt register bank
`timescale 1ns/1ns
module tb;
  localparam int          CW  = 4;
  localparam logic [15:0] CNT = sdsi_pkg::ADR_DROP_CNT;
  localparam logic [15:0] MSK = sdsi_pkg::ADR_MASK;
  localparam logic [15:0] PND = sdsi_pkg::ADR_PENDING;
  localparam logic [15:0] EVS = sdsi_pkg::ADR_EVT_STAT;
  localparam logic [15:0] EVE = sdsi_pkg::ADR_EVT_EN;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, irq, err;
  logic        drop_valid = 1'b0;
  logic        drop_rate_limited = 1'b0;
  logic [1:0]  drop_port = 2'h0;
  logic [3:0]  drop_reason = 4'h0;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #25 pclk = ~pclk;
  sdsi_switch_drop_status_irq #(.CNT_W(CW)) sdsi_switch_drop_status_irq_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .drop_valid, .drop_rate_limited, .drop_port, .drop_reason, .irq);
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), rdat, exp);
  endtask : rd
  task automatic drop(input logic [1:0] p, input logic [3:0] r, input logic rl);
    @(posedge pclk);
    drop_valid <= 1'b1;
    drop_port <= p;
    drop_reason <= r;
    drop_rate_limited <= rl;
    @(posedge pclk);
    drop_valid <= 1'b0;
  endtask : drop
  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask : chk_irq
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(CNT, 32'h0);
    rd(MSK, 32'h1);
    rd(PND, 32'h0);
    rd(EVS, 32'h0);
    rd(EVE, 32'h0);
    rd(16'h7090, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    drop(2'h0, sdsi_pkg::RSN_RED, 1'b0);
    drop(2'h2, sdsi_pkg::RSN_YELLOW, 1'b0);
    drop(2'h1, sdsi_pkg::RSN_NO_BUF, 1'b0);
    chk_irq(1'b0);
    rd(PND, {18'h0, 4'h9, 2'h2, 1'b1, 4'h1, 2'h0, 1'b1});
    rd(PND, 32'h0);
    rd(EVS, 32'h5);
    apb(1'b1, EVS, 32'h7);
    rd(EVS, 32'h0);
    for (int r = 0; r < 16; r++) begin
      drop(2'h1, 4'(r), 1'b0);
      rd(PND, (r <= 6 || r == 9) ? {25'h0, 4'(r), 2'h1, 1'b1} : 32'h0);
    end
    drop(2'h3, sdsi_pkg::RSN_RED, 1'b0);
    rd(PND, 32'h0);
    for (int i = 0; i < 3; i++) drop(2'h2, sdsi_pkg::RSN_RED, 1'b1);
    drop(2'h1, sdsi_pkg::RSN_RED, 1'b1);
    drop(2'h2, sdsi_pkg::RSN_RED, 1'b0);
    rd(CNT, 32'h3);
    rd(CNT, 32'h0);
    for (int i = 0; i < 17; i++) drop(2'h2, sdsi_pkg::RSN_RED, 1'b1);
    rd(CNT, 32'((1 << CW) - 1));
    rd(CNT, 32'h0);
    rd(EVS, 32'h7);
    apb(1'b1, EVS, 32'h7);
    rd(PND, {18'h0, 4'h1, 2'h2, 1'b1, 4'h1, 2'h2, 1'b1});
    apb(1'b1, MSK, 32'hfffffffe);
    rd(MSK, 32'h0);
    chk_irq(1'b0);
    drop(2'h0, sdsi_pkg::RSN_NO_DESC, 1'b0);
    chk_irq(1'b1);
    apb(1'b1, MSK, 32'h1);
    chk_irq(1'b0);
    apb(1'b1, MSK, 32'h0);
    chk_irq(1'b1);
    rd(PND, {25'h0, 4'h3, 2'h0, 1'b1});
    chk_irq(1'b0);
    apb(1'b1, EVE, 32'h1);
    rd(EVE, 32'h1);
    chk_irq(1'b1);
    apb(1'b1, EVS, 32'h7);
    chk_irq(1'b0);
    apb(1'b1, CNT, 32'h5);
    chk("mapped write error", {31'h0, err}, 32'h0);
    apb(1'b1, PND, 32'h3);
    rd(CNT, 32'h0);
    rd(PND, 32'h0);
    apb(1'b1, 16'h7090, 32'h1);
    chk("unmapped write error", {31'h0, err}, 32'h1);
    summarize();
  end
endmodule : tb
